// file: ph_pkg.sv
// Summary of operation
// - float compute/multiply result used by next compute: one stall cycle
// - both multiplier operands from dual compute: one stall at N-2, two at N-1
// - float multiply then fixed ALU using its result: no stall
// - result into 64-bit float compute: two stalls adjacent, one with a gap
// - unconditional address_generator load then use: four stall cycles
// - conditional address_generator load after condition set then use: five stalls
// - condition set, conditional post-modify, same index use: five stalls
// - immediate address_generator load then use: no stall
// - one extra address stall for arith_status_register condition plus sign extension
// - unconditional branch on predictor miss or disabled: flush six, four delayed
// - conditional branch after condition set: eleven, nine delayed, plus one for status
// - interrupt_return, delayed or not: seven-cycle flush
// - frame call or restore then frame_pointer_index use: six extra stalls
// - index load then indirect branch: four, five conditional, plus one sign extension
// - short counter loop or arithmetic loop termination: eleven-cycle flush
// - current_loop_counter write then expired test: one stall; loop start none
// - unrolled loop change of flow or return at position N: four minus N
// - jump with loop abort: four extra stall cycles
// - loop stack change then return or jump: five stall cycles
// - call/return target a return: three stalls; target a jump: one
// - system_register_group update to access two later: five; second_element_enable none
// - float or multiply result moved out of its element next: one stall
package ph_pkg;

  localparam int CNT_W = 5;
  typedef logic [CNT_W-1:0] ph_cnt_t;

  localparam ph_cnt_t FP_FWD_STALL = 5'h01;
  localparam ph_cnt_t DUAL_N1_STALL = 5'h02;
  localparam ph_cnt_t DUAL_N2_STALL = 5'h01;
  localparam ph_cnt_t F64_N1_STALL = 5'h02;
  localparam ph_cnt_t F64_N2_STALL = 5'h01;
  localparam ph_cnt_t AG_LOAD_STALL = 5'h04;
  localparam ph_cnt_t AG_COND_STALL = 5'h05;
  localparam ph_cnt_t AG_EXTRA_STALL = 5'h01;
  localparam ph_cnt_t FRAME_STALL = 5'h06;
  localparam ph_cnt_t EXPIRED_STALL = 5'h01;
  localparam ph_cnt_t LOOP_POS_BASE = 5'h04;
  localparam ph_cnt_t ABORT_STALL = 5'h04;
  localparam ph_cnt_t LSTK_STALL = 5'h05;
  localparam ph_cnt_t TGT_RET_STALL = 5'h03;
  localparam ph_cnt_t TGT_JUMP_STALL = 5'h01;
  localparam ph_cnt_t SYSREG_STALL = 5'h05;
  localparam ph_cnt_t MOVE_OUT_STALL = 5'h01;

  localparam ph_cnt_t BR_FLUSH = 5'h06;
  localparam ph_cnt_t BR_DLY_FLUSH = 5'h04;
  localparam ph_cnt_t CBR_FLUSH = 5'h0B;
  localparam ph_cnt_t CBR_DLY_FLUSH = 5'h09;
  localparam ph_cnt_t CBR_ASTAT_EXTRA = 5'h01;
  localparam ph_cnt_t RET_INT_FLUSH = 5'h07;
  localparam ph_cnt_t LOOP_TERM_FLUSH = 5'h0B;

  localparam int AW = 8;
  localparam logic [AW-1:0] REG_CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] REG_STAT_OFS = 8'h04;
  localparam logic [AW-1:0] REG_STALLS_OFS = 8'h08;
  localparam logic [AW-1:0] REG_FLUSHES_OFS = 8'h0C;
  localparam int CTRL_PRED_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic is_compute;
    logic fp_result;
    logic is_mul;
    logic fixed_alu;
    logic dual;
    logic f64;
    logic loads_data;
    logic [3:0] dst;
    logic [3:0] dst2;
    logic [3:0] src_a;
    logic [3:0] src_b;
    logic ag_load;
    logic ag_cond;
    logic ag_imm;
    logic sign_ext;
    logic cond_postmod;
    logic ag_use;
    logic [3:0] ag_reg;
    logic [3:0] use_reg;
    logic sets_cond;
    logic cond_astat;
    logic branch;
    logic br_cond;
    logic br_delayed;
    logic br_indirect;
    logic int_return;
    logic pred_hit;
    logic frame_op;
    logic frame_use;
    logic loop_term;
    logic cur_cnt_wr;
    logic tests_expired;
    logic unrolled_cof;
    logic ret_to_loop;
    logic [1:0] pos;
    logic loop_abort;
    logic lstk_mod;
    logic flow_ret;
    logic tgt_return;
    logic tgt_jump;
    logic sysreg_upd;
    logic second_element_enable_only;
    logic mem_access;
    logic move_out;
    logic [3:0] move_src;
  } ph_instr_t;

  typedef enum logic [1:0] {ST_RUN, ST_STALL, ST_FLUSH} ph_state_t;

  typedef struct packed {
    ph_state_t st;
    ph_cnt_t cnt;
    logic served;
    logic flush;
    ph_instr_t p1;
    ph_instr_t p2;
    logic pred_en;
    logic [31:0] stalls;
    logic [31:0] flushes;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ph_regs_t;

endpackage

// file: ph_hazard_ctrl.sv
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module ph_hazard_ctrl
  import ph_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic instr_valid_in,
  input wire ph_instr_t instr_in,
  output logic issue_ready_out,
  output logic hold_out,
  output logic bubble_out,
  output logic flush_out,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [AW-1:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [AW-1:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out
);

  ph_regs_t q;
  ph_regs_t d;
  ph_cnt_t need_c;
  ph_cnt_t flush_c;
  logic go;
  logic wr_go;
  logic rd_go;
  logic [AW-1:0] wa;
  logic [AW-1:0] ra;

  function automatic ph_cnt_t mx(input ph_cnt_t a, input ph_cnt_t b);
    mx = (a > b) ? a : b;
  endfunction

  function automatic ph_cnt_t data_stall(input ph_instr_t c, input ph_instr_t a,
                                         input ph_instr_t b);
    ph_cnt_t s;
    ph_cnt_t x;
    logic hit_a;
    logic hit_b;
    logic ag_a;
    logic sx;
    s = '0;
    x = '0;
    hit_a = (c.src_a == a.dst) || (c.src_b == a.dst);
    hit_b = (c.src_a == b.dst) || (c.src_b == b.dst);
    ag_a = c.ag_use && (a.ag_reg == c.use_reg);
    sx = a.sign_ext && b.cond_astat;
    // a multiply result reaches the fixed ALU without penalty
    if (a.is_compute && a.fp_result && c.is_compute && hit_a
        && !(a.is_mul && c.fixed_alu)) begin
      s = mx(s, FP_FWD_STALL);
    end
    if (c.is_mul && a.dual && (c.src_a == a.dst || c.src_a == a.dst2)
        && (c.src_b == a.dst || c.src_b == a.dst2)) begin
      s = mx(s, DUAL_N1_STALL);
    end else if (c.is_mul && b.dual && (c.src_a == b.dst || c.src_a == b.dst2)
                 && (c.src_b == b.dst || c.src_b == b.dst2)) begin
      s = mx(s, DUAL_N2_STALL);
    end
    if (c.f64 && (a.is_compute || a.loads_data) && hit_a) begin
      s = mx(s, F64_N1_STALL);
    end else if (c.f64 && (b.is_compute || b.loads_data) && hit_b) begin
      s = mx(s, F64_N2_STALL);
    end
    // immediate loads are masked out by ag_imm, so they cost nothing
    if (ag_a && a.ag_load && !a.ag_imm && !a.ag_cond) begin
      x = AG_LOAD_STALL;
      if (c.br_indirect && a.sign_ext) begin
        x = ph_cnt_t'(x + AG_EXTRA_STALL);
      end
    end
    if (ag_a && b.sets_cond && ((a.ag_load && a.ag_cond && !a.ag_imm)
        || a.cond_postmod)) begin
      x = AG_COND_STALL;
      if (sx || (c.br_indirect && a.sign_ext)) begin
        x = ph_cnt_t'(x + AG_EXTRA_STALL);
      end
    end
    s = mx(s, x);
    if (a.cur_cnt_wr && c.tests_expired) begin
      s = mx(s, EXPIRED_STALL);
    end
    if (c.unrolled_cof || c.ret_to_loop) begin
      s = mx(s, ph_cnt_t'(LOOP_POS_BASE - ph_cnt_t'(c.pos)));
    end
    if (b.sysreg_upd && !b.second_element_enable_only && c.mem_access) begin
      s = mx(s, SYSREG_STALL);
    end
    if (a.is_compute && (a.fp_result || a.is_mul) && c.move_out
        && c.move_src == a.dst) begin
      s = mx(s, MOVE_OUT_STALL);
    end
    // branch side costs add on top of data hazards
    if (a.frame_op && c.frame_use) begin
      s = ph_cnt_t'(s + FRAME_STALL);
    end
    if (c.loop_abort) begin
      s = ph_cnt_t'(s + ABORT_STALL);
    end
    if (a.lstk_mod && c.flow_ret) begin
      s = ph_cnt_t'(s + LSTK_STALL);
    end
    if (c.tgt_return) begin
      s = ph_cnt_t'(s + TGT_RET_STALL);
    end else if (c.tgt_jump) begin
      s = ph_cnt_t'(s + TGT_JUMP_STALL);
    end
    data_stall = s;
  endfunction

  function automatic ph_cnt_t flush_len(input ph_instr_t c, input ph_instr_t a,
                                        input logic pred_en);
    ph_cnt_t f;
    f = '0;
    if (c.int_return) begin
      f = RET_INT_FLUSH;
    end else if (c.loop_term) begin
      f = LOOP_TERM_FLUSH;
    end else if (c.branch && (!c.pred_hit || !pred_en)) begin
      if (c.br_cond && a.sets_cond) begin
        f = c.br_delayed ? CBR_DLY_FLUSH : CBR_FLUSH;
        if (a.cond_astat) begin
          f = ph_cnt_t'(f + CBR_ASTAT_EXTRA);
        end
      end else begin
        f = c.br_delayed ? BR_DLY_FLUSH : BR_FLUSH;
      end
    end
    flush_len = f;
  endfunction

  assign need_c = data_stall(instr_in, q.p1, q.p2);
  assign flush_c = flush_len(instr_in, q.p1, q.pred_en);
  assign issue_ready_out = (q.st == ST_RUN) && (need_c == '0 || q.served);
  assign go = instr_valid_in && issue_ready_out;
  // issue holds through the detect cycle and every stall-state cycle
  assign hold_out = (q.st == ST_STALL)
                    || (q.st == ST_RUN && instr_valid_in && !issue_ready_out);
  assign bubble_out = hold_out || (q.st == ST_FLUSH);
  assign flush_out = q.flush;
  assign wr_go = awvalid_in && wvalid_in && !q.bvalid;
  assign rd_go = arvalid_in && !q.rvalid;
  assign awready_out = wr_go;
  assign wready_out = wr_go;
  assign arready_out = rd_go;
  assign bvalid_out = q.bvalid;
  assign bresp_out = q.bresp;
  assign rvalid_out = q.rvalid;
  assign rdata_out = q.rdata;
  assign rresp_out = q.rresp;
  assign wa = {awaddr_in[AW-1:2], 2'b00};
  assign ra = {araddr_in[AW-1:2], 2'b00};

  always_comb begin
    d = q;
    d.flush = 1'b0;
    case (q.st)
      ST_RUN: begin
        if (go) begin
          d.served = 1'b0;
          d.p1 = instr_in;
          d.p2 = q.p1;
          if (flush_c != '0) begin
            d.flush = 1'b1;
            d.st = ST_FLUSH;
            d.cnt = flush_c;
          end
        end else if (instr_valid_in) begin
          d.served = 1'b1;
          if (need_c > 5'h01) begin
            d.st = ST_STALL;
            d.cnt = ph_cnt_t'(need_c - 5'h01);
          end
        end else begin
          // an empty issue slot ages the history like an unrelated instruction
          d.p1 = '0;
          d.p2 = q.p1;
        end
      end
      ST_STALL, ST_FLUSH: begin
        d.cnt = ph_cnt_t'(q.cnt - 5'h01);
        if (q.cnt == 5'h01) begin
          d.st = ST_RUN;
        end
      end
      default: begin
        d.st = ST_RUN;
      end
    endcase
    if (hold_out) begin
      d.stalls = q.stalls + 32'h0000_0001;
    end
    if (q.st == ST_FLUSH) begin
      d.flushes = q.flushes + 32'h0000_0001;
    end
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (wa == REG_CTRL_OFS) begin
        if (wstrb_in[0]) begin
          d.pred_en = wdata_in[CTRL_PRED_EN_BIT];
        end
      end else if (wa != REG_STAT_OFS && wa != REG_STALLS_OFS && wa != REG_FLUSHES_OFS) begin
        d.bresp = RESP_SLVERR;
      end
    end else if (q.bvalid && bready_in) begin
      d.bvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case (ra)
        REG_CTRL_OFS: d.rdata = {31'h0000_0000, q.pred_en};
        REG_STAT_OFS: d.rdata = {24'h00_0000, q.cnt, q.served, q.st};
        REG_STALLS_OFS: d.rdata = q.stalls;
        REG_FLUSHES_OFS: d.rdata = q.flushes;
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && rready_in) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
      q.pred_en <= CTRL_RST[CTRL_PRED_EN_BIT];
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_detect;
    q.st == ST_RUN && instr_valid_in && !q.served;
  endsequence

  sequence s_flush_six;
    flush_out ##0 (q.st == ST_FLUSH) [*6] ##1 q.st == ST_RUN;
  endsequence

  sequence s_flush_seven;
    flush_out ##0 (q.st == ST_FLUSH) [*7] ##1 q.st == ST_RUN;
  endsequence

  chk_fp_fwd_stall: assert property (
    instr_valid_in && q.p1.is_compute && q.p1.fp_result && !q.p1.is_mul
    && instr_in.is_compute && instr_in.src_a == q.p1.dst |-> need_c >= 5'h01)
    else $error("float forward did not stall");

  chk_dual_adjacent: assert property (
    instr_valid_in && instr_in.is_mul && q.p1.dual && instr_in.src_a == q.p1.dst
    && instr_in.src_b == q.p1.dst2 |-> need_c >= 5'h02)
    else $error("dual forward stall too short");

  chk_f64_adjacent: assert property (
    instr_valid_in && instr_in.f64 && q.p1.loads_data && instr_in.src_b == q.p1.dst
    |-> need_c >= 5'h02)
    else $error("64-bit forward stall too short");

  chk_ag_load_use: assert property (
    instr_valid_in && instr_in.ag_use && q.p1.ag_load && !q.p1.ag_cond && !q.p1.ag_imm
    && q.p1.ag_reg == instr_in.use_reg |-> need_c >= 5'h04)
    else $error("index load to use stall too short");

  chk_ag_cond_use: assert property (
    instr_valid_in && instr_in.ag_use && q.p1.ag_load && q.p1.ag_cond && !q.p1.ag_imm
    && q.p2.sets_cond && q.p1.ag_reg == instr_in.use_reg |-> need_c >= 5'h05)
    else $error("conditional index load stall too short");

  chk_stall_four: assert property (
    s_detect ##0 need_c == 5'h04 |-> hold_out [*4] ##1 (q.st == ST_RUN && q.served))
    else $error("four-cycle stall window wrong");

  chk_branch_flush: assert property (
    go && instr_in.branch && !instr_in.br_cond && !instr_in.br_delayed
    && !instr_in.int_return && !instr_in.loop_term && !q.pred_en |=> s_flush_six)
    else $error("undelayed branch flush not six cycles");

  chk_rti_flush: assert property (
    go && instr_in.int_return |=> s_flush_seven)
    else $error("interrupt return flush not seven cycles");

  chk_loop_term: assert property (
    go && instr_in.loop_term && !instr_in.int_return |-> flush_c == 5'h0B)
    else $error("loop termination flush not eleven");

  chk_hold_bubble: assert property (
    hold_out |-> bubble_out && !issue_ready_out && !go)
    else $error("held instruction escaped issue");

  sequence s_served;
    q.st == ST_RUN && q.served && issue_ready_out;
  endsequence

  chk_stall_one: assert property (
    s_detect ##0 need_c == 5'h01 |=> s_served)
    else $error("one-cycle stall window wrong");

  chk_postmod_use: assert property (
    instr_valid_in && instr_in.ag_use && q.p1.cond_postmod && q.p2.sets_cond
    && q.p1.ag_reg == instr_in.use_reg |-> need_c >= 5'h05)
    else $error("post-modify to use stall too short");

  chk_cond_branch: assert property (
    go && instr_in.branch && instr_in.br_cond && !instr_in.br_delayed && q.p1.sets_cond
    && !q.p1.cond_astat && !instr_in.int_return && !instr_in.loop_term && !q.pred_en
    |-> flush_c == 5'h0B)
    else $error("conditional branch flush not eleven");

  chk_frame_use: assert property (
    instr_valid_in && q.p1.frame_op && instr_in.frame_use |-> need_c >= 5'h06)
    else $error("frame pointer use stall too short");

  chk_expired_test: assert property (
    instr_valid_in && q.p1.cur_cnt_wr && instr_in.tests_expired |-> need_c >= 5'h01)
    else $error("loop counter test did not stall");

  chk_abort_stall: assert property (
    instr_valid_in && instr_in.loop_abort |-> need_c >= 5'h04)
    else $error("loop abort stall too short");

  chk_lstk_return: assert property (
    instr_valid_in && q.p1.lstk_mod && instr_in.flow_ret |-> need_c >= 5'h05)
    else $error("loop stack to return stall too short");

  chk_sysreg_access: assert property (
    instr_valid_in && q.p2.sysreg_upd && !q.p2.second_element_enable_only && instr_in.mem_access
    |-> need_c >= 5'h05)
    else $error("system register to access stall too short");

  chk_move_out: assert property (
    instr_valid_in && q.p1.is_compute && q.p1.fp_result && instr_in.move_out
    && instr_in.move_src == q.p1.dst |-> need_c >= 5'h01)
    else $error("result move out did not stall");

endmodule // ph_hazard_ctrl

// file: ph_tb.sv
`timescale 1ns/1ps
module tb;
  import ph_pkg::*;
  logic core_clk_in = 1'h0;
  logic nrst_in = 1'h0;
  logic instr_valid_in = 1'h0;
  ph_instr_t instr_in = '0;
  logic awvalid_in = 1'h0, wvalid_in = 1'h0, bready_in = 1'h0;
  logic arvalid_in = 1'h0, rready_in = 1'h0;
  logic [AW-1:0] awaddr_in = '0, araddr_in = '0;
  logic [31:0] wdata_in = '0;
  logic [3:0] wstrb_in = '0;
  logic issue_ready_out, hold_out, bubble_out, flush_out;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out, rs;
  logic [31:0] rdata_out, rd;
  logic [3:0] r, s;
  int fails = 0, check_count = 0, stall_sum = 0, flush_sum = 0;
  ph_instr_t e, a, b, c;

  always #50 core_clk_in = ~core_clk_in;

  ph_hazard_ctrl ph_hazard_ctrl_i (.core_clk_in, .nrst_in, .instr_valid_in, .instr_in,
    .issue_ready_out, .hold_out, .bubble_out, .flush_out, .awvalid_in, .awready_out,
    .awaddr_in, .wvalid_in, .wready_out, .wdata_in, .wstrb_in, .bvalid_out, .bready_in,
    .bresp_out, .arvalid_in, .arready_out, .araddr_in, .rvalid_out, .rready_in,
    .rdata_out, .rresp_out);

  task wrap_up;
    $display("mismatches %0d comparisons %0d", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task cmp_num(input int got, input int exp);
    cmp_word(32'(got), 32'(exp));
  endtask

  // ends on the accepting edge so the caller can present the next one
  task wait_acc(input int es);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (issue_ready_out !== 1'h1 && n < 40) begin
      cmp_word({31'h0, hold_out}, 32'h0000_0001);
      cmp_word({31'h0, bubble_out}, 32'h0000_0001);
      n++;
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    cmp_num(n, es);
    stall_sum += es;
  endtask

  // three back-to-back issues, counts taken on the last one
  task seq(input ph_instr_t x, y, z, input int es, ef);
    int n;
    n = 0;
    @(posedge core_clk_in);
    instr_valid_in <= 1'h1;
    instr_in <= x;
    wait_acc(0);
    instr_in <= y;
    wait_acc(0);
    instr_in <= z;
    wait_acc(es);
    instr_valid_in <= 1'h0;
    instr_in <= '0;
    @(negedge core_clk_in);
    cmp_word({31'h0, flush_out}, 32'(ef > 0));
    while (issue_ready_out !== 1'h1 && n < 40) begin
      cmp_word({31'h0, bubble_out}, 32'h0000_0001);
      cmp_word({31'h0, hold_out}, 32'h0000_0000);
      n++;
      @(negedge core_clk_in);
    end
    cmp_num(n, ef);
    flush_sum += ef;
    // idle cycles empty the two-deep history
    repeat (3) @(posedge core_clk_in);
  endtask

  task axw(input logic [7:0] ad, input logic [31:0] wd, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk_in);
    awvalid_in <= 1'h1;
    wvalid_in <= 1'h1;
    awaddr_in <= ad;
    wdata_in <= wd;
    wstrb_in <= 4'hf;
    bready_in <= 1'h1;
    @(negedge core_clk_in);
    while (!(awready_out === 1'h1 && wready_out === 1'h1) && n < 40) begin
      n++;
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    awvalid_in <= 1'h0;
    wvalid_in <= 1'h0;
    @(negedge core_clk_in);
    while (bvalid_out !== 1'h1 && n < 80) begin
      n++;
      @(negedge core_clk_in);
    end
    rs = bresp_out;
    @(posedge core_clk_in);
    bready_in <= 1'h0;
    cmp_word({30'h0, rs}, {30'h0, er});
  endtask

  task axr(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk_in);
    arvalid_in <= 1'h1;
    araddr_in <= ad;
    rready_in <= 1'h1;
    @(negedge core_clk_in);
    while (arready_out !== 1'h1 && n < 40) begin
      n++;
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    arvalid_in <= 1'h0;
    @(negedge core_clk_in);
    while (rvalid_out !== 1'h1 && n < 80) begin
      n++;
      @(negedge core_clk_in);
    end
    rs = rresp_out;
    rd = rdata_out;
    @(posedge core_clk_in);
    rready_in <= 1'h0;
    cmp_word(rd, ed);
    cmp_word({30'h0, rs}, {30'h0, er});
  endtask

  initial begin
    #(100 * 20000);
    fails++;
    wrap_up;
  end

  initial begin
    void'($urandom(67));
    e = '0;
    r = 4'($urandom_range(15, 1));
    s = 4'(r % 15 + 1);
    repeat (8) @(posedge core_clk_in);
    nrst_in <= 1'h1;
    axr(REG_CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    axr(8'h10, 32'h0000_0000, RESP_SLVERR);
    axw(8'h14, 32'h0000_0001, RESP_SLVERR);
    axw(REG_STALLS_OFS, 32'hffff_ffff, RESP_OKAY);
    axr(REG_STALLS_OFS, 32'h0000_0000, RESP_OKAY);
    // predictor off: every branch below except the interrupt returns pays the miss figures
    axw(REG_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    axr(REG_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    a = e;
    a.is_compute = '1;
    a.fp_result = '1;
    a.dst = r;
    b = e;
    b.is_compute = '1;
    b.src_a = r;
    seq(e, a, b, 1, 0);
    c = e;
    c.move_out = '1;
    c.move_src = r;
    seq(e, a, c, 1, 0);
    b.f64 = '1;
    seq(e, a, b, 2, 0);
    seq(a, e, b, 1, 0);
    a.is_mul = '1;
    b.f64 = '0;
    b.fixed_alu = '1;
    seq(e, a, b, 0, 0);
    a = e;
    a.is_compute = '1;
    a.dual = '1;
    a.fp_result = '1;
    a.dst = r;
    a.dst2 = s;
    b = e;
    b.is_compute = '1;
    b.is_mul = '1;
    b.src_a = r;
    b.src_b = s;
    seq(e, a, b, 2, 0);
    seq(a, e, b, 1, 0);
    a = e;
    a.ag_load = '1;
    a.ag_reg = r;
    b = e;
    b.ag_use = '1;
    b.use_reg = r;
    seq(e, a, b, 4, 0);
    c = e;
    c.sets_cond = '1;
    a.ag_cond = '1;
    seq(c, a, b, 5, 0);
    c.cond_astat = '1;
    a.sign_ext = '1;
    seq(c, a, b, 6, 0);
    a = e;
    a.ag_imm = '1;
    a.ag_reg = r;
    seq(e, a, b, 0, 0);
    a.ag_imm = '0;
    a.cond_postmod = '1;
    c.cond_astat = '0;
    seq(c, a, b, 5, 0);
    a = e;
    a.ag_load = '1;
    a.ag_reg = r;
    b = e;
    b.branch = '1;
    b.br_indirect = '1;
    b.ag_use = '1;
    b.use_reg = r;
    seq(e, a, b, 4, 6);
    a.sign_ext = '1;
    seq(e, a, b, 5, 6);
    for (int k = 0; k < 2; k++) begin
      a = e;
      a.branch = '1;
      a.br_delayed = k[0];
      seq(e, e, a, 0, k ? 4 : 6);
      a.br_cond = '1;
      c.cond_astat = '0;
      seq(e, c, a, 0, k ? 9 : 11);
      c.cond_astat = '1;
      seq(e, c, a, 0, k ? 10 : 12);
      a.br_cond = '0;
      a.int_return = '1;
      seq(e, e, a, 0, 7);
    end
    a = e;
    a.branch = '1;
    a.loop_abort = '1;
    seq(e, e, a, 4, 6);
    a = e;
    a.loop_term = '1;
    seq(e, e, a, 0, 11);
    a = e;
    a.frame_op = '1;
    b = e;
    b.frame_use = '1;
    seq(e, a, b, 6, 0);
    a = e;
    a.cur_cnt_wr = '1;
    b = e;
    b.tests_expired = '1;
    seq(e, a, b, 1, 0);
    for (int k = 0; k < 4; k++) begin
      a = e;
      a.unrolled_cof = '1;
      a.pos = k[1:0];
      seq(e, e, a, 4 - k, 0);
      a.unrolled_cof = '0;
      a.ret_to_loop = '1;
      seq(e, e, a, 4 - k, 0);
    end
    a = e;
    a.lstk_mod = '1;
    b = e;
    b.flow_ret = '1;
    seq(e, a, b, 5, 0);
    a = e;
    a.tgt_return = '1;
    seq(e, e, a, 3, 0);
    a.tgt_return = '0;
    a.tgt_jump = '1;
    seq(e, e, a, 1, 0);
    a = e;
    a.sysreg_upd = '1;
    b = e;
    b.mem_access = '1;
    seq(a, e, b, 5, 0);
    a.second_element_enable_only = '1;
    seq(a, e, b, 0, 0);
    axr(REG_STALLS_OFS, 32'(stall_sum), RESP_OKAY);
    axr(REG_FLUSHES_OFS, 32'(flush_sum), RESP_OKAY);
    wrap_up;
  end
endmodule // tb
